// *** rtl/psdc_regs.svh ***
// Purpose: bit positions, widths and timing figures of the synthesizer core
// Assumes: serial word is 18 bits, address bit in bit 0
// Notes:   definitions only
`ifndef PSDC_REGS_SVH
`define PSDC_REGS_SVH

`define PSDC_SHIFT_W        18
`define PSDC_ADDR_BIT       0
`define PSDC_ADDR_REF       1'h1
`define PSDC_ADDR_FB        1'h0

`define PSDC_REF_LATCH_W    14
`define PSDC_REF_RATIO_W    10
`define PSDC_REF_RATIO_LSB  0
`define PSDC_REF_FLOAT_BIT  10
`define PSDC_REF_POL_BIT    11
`define PSDC_REF_RSV_BIT    12
`define PSDC_REF_TEST_BIT   13

`define PSDC_FB_LATCH_W     17
`define PSDC_FB_SLEEP_BIT   0
`define PSDC_FB_CLEAR_BIT   1
`define PSDC_FB_SWALLOW_LSB 2
`define PSDC_FB_SWALLOW_W   5
`define PSDC_FB_MAIN_LSB    7
`define PSDC_FB_MAIN_W      10

`define PSDC_PRESCALE_P     32
`define PSDC_CLK_MHZ        200
`define PSDC_REF_MAX_MHZ    40
`define PSDC_PFD_MAX_MHZ    10
`define PSDC_CLK_PER_REF    (`PSDC_CLK_MHZ / `PSDC_REF_MAX_MHZ)

`endif

// *** rtl/psdc_pkg.sv ***
// Purpose: types shared by the synthesizer core and its bench
// Assumes: psdc_regs.svh supplies the widths
// Notes:   mode codes are one-hot
`include "psdc_regs.svh"
package psdc_pkg;

    typedef enum logic [2:0] {
        MODE_RUN   = 3'b001,
        MODE_CLEAR = 3'b010,
        MODE_SLEEP = 3'b100
    } psdc_mode_t;

    typedef struct packed {
        logic clk;
        logic data;
        logic load;
    } psdc_serial_t;

    typedef struct packed {
        logic level;
        logic oeN;
    } psdc_pump_t;

    typedef struct packed {
        logic [`PSDC_SHIFT_W-1:0]      shiftReg;
        logic [`PSDC_REF_LATCH_W-1:0]  refLatch;
        logic [`PSDC_FB_LATCH_W-1:0]   fbLatch;
        logic                          serialClkPrev;
        logic                          loadPrev;
        logic                          refClkPrev;
        logic                          preOutPrev;
        logic [`PSDC_REF_RATIO_W-1:0]  refCnt;
        logic [`PSDC_FB_SWALLOW_W-1:0] swCnt;
        logic [`PSDC_FB_MAIN_W-1:0]    mainCnt;
        logic                          refFlag;
        logic                          fbFlag;
        logic                          refOut;
        logic                          fbOut;
        psdc_mode_t                    mode;
        psdc_pump_t                    pump;
        logic                          modulusSel;
        logic                          refOscEnable;
        logic                          rfInputEnable;
    } psdc_state_t;

endpackage

// *** rtl/psdc_core.sv ***
// Purpose: serial load port, reference and feedback dividers, detector and pump control
// Assumes: all pins are synchronous to clk; clk far faster than ref and prescaler edges
// Notes:   pump pin is level plus active-low enable; outputs are registered
// Behaviour
// - serial bit shifts in on serial clock rise
// - load strobe rise copies data to latch
// - address 1 reference latch, 0 feedback latch
// - reference latch field layout, bits above ignored
// - reference divider ratio 2 to 1023
// - reference divider runs from reference clock
// - feedback: 5-bit swallow, 10-bit main counter
// - feedback ratios 992 to 32767 continuous
// - prescaler 32/33, counters choose modulus
// - detector compares dividers, requests up/down
// - polarity bit swaps up and down
// - up to supply, down to ground, else float
// - test mode puts divider output on pump
// - enable pin low powers down, floats pump
// - sleep bit stops dividers and inputs
// - powered down floats pump and detector
// - counter clear restarts dividers aligned
// - serial port works in every power mode
// - A cycles of 33, then B-A of 32
// - control pair selects sync, clear, async
// - test polarity selects reference or feedback
`include "psdc_regs.svh"
module psdc_core (
    input  wire logic                  clk,           // core clock, 200 MHz
    input  wire logic                  rst,           // async reset, active high
    input  wire logic                  clkEn,         // freezes all state while low
    input  wire psdc_pkg::psdc_serial_t serialIn,     // serial clock, data, load strobe
    input  wire logic                  chipEnable,    // device enable pin
    input  wire logic                  refClockIn,    // reference oscillator level
    input  wire logic                  prescalerOut,  // prescaler output level
    output logic                       modulusSel,    // 1 asks prescaler for 33
    output psdc_pkg::psdc_pump_t       pumpOutput,    // pump pin level and enable
    output logic                       refOscEnable,  // reference input biased
    output logic                       rfInputEnable  // rf input biased
);

    ////////////////////////////////////////////////////////////////////////////////
    psdc_pkg::psdc_state_t st;
    psdc_pkg::psdc_state_t next_st;

    logic                          serEdge;
    logic                          ldEdge;
    logic                          refEdge;
    logic                          preEdge;
    logic                          refPulse;
    logic                          fbPulse;
    logic                          upReq;
    logic                          dnReq;
    logic [`PSDC_REF_RATIO_W-1:0]  refRatio;
    logic [`PSDC_FB_SWALLOW_W-1:0] swallowCount;
    logic [`PSDC_FB_MAIN_W-1:0]    mainCount;
    logic                          pumpFloatBit;
    logic                          detectorPolarityBit;
    logic                          testBit;
    logic                          sleepBit;
    logic                          counterClearBit;
    logic                          asyncDown;

    assign refRatio            = st.refLatch[`PSDC_REF_RATIO_LSB +: `PSDC_REF_RATIO_W];
    assign pumpFloatBit        = st.refLatch[`PSDC_REF_FLOAT_BIT];
    assign detectorPolarityBit = st.refLatch[`PSDC_REF_POL_BIT];
    assign testBit             = st.refLatch[`PSDC_REF_TEST_BIT];
    assign swallowCount        = st.fbLatch[`PSDC_FB_SWALLOW_LSB +: `PSDC_FB_SWALLOW_W];
    assign mainCount           = st.fbLatch[`PSDC_FB_MAIN_LSB +: `PSDC_FB_MAIN_W];
    assign sleepBit            = st.fbLatch[`PSDC_FB_SLEEP_BIT];
    assign counterClearBit     = st.fbLatch[`PSDC_FB_CLEAR_BIT];

    assign serEdge   = serialIn.clk & ~st.serialClkPrev;
    assign ldEdge    = serialIn.load & ~st.loadPrev;
    assign refEdge   = refClockIn & ~st.refClkPrev;
    assign preEdge   = prescalerOut & ~st.preOutPrev;
    // enable pin low or both control bits set: down at once, no pulse gating
    assign asyncDown = ~chipEnable | (counterClearBit & sleepBit);

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st               = st;
        refPulse              = 1'b0;
        fbPulse               = 1'b0;
        upReq                 = 1'b0;
        dnReq                 = 1'b0;
        next_st.serialClkPrev = serialIn.clk;
        next_st.loadPrev      = serialIn.load;
        next_st.refClkPrev    = refClockIn;
        next_st.preOutPrev    = prescalerOut;

        // serial path ignores power mode so software can reprogram while asleep
        if (serEdge) begin
            next_st.shiftReg = {st.shiftReg[`PSDC_SHIFT_W-2:0], serialIn.data};
        end
        if (ldEdge) begin
            if (st.shiftReg[`PSDC_ADDR_BIT] == `PSDC_ADDR_REF) begin
                next_st.refLatch = st.shiftReg[`PSDC_REF_LATCH_W:1];
            end else begin
                next_st.fbLatch = st.shiftReg[`PSDC_FB_LATCH_W:1];
            end
        end

        case (st.mode)
            psdc_pkg::MODE_RUN: begin
                if (asyncDown) begin
                    next_st.mode = psdc_pkg::MODE_SLEEP;
                end else if (counterClearBit) begin
                    next_st.mode = psdc_pkg::MODE_CLEAR;
                end else if (sleepBit && !st.refFlag && !st.fbFlag) begin
                    // wait for the pump pulse in flight to end
                    next_st.mode = psdc_pkg::MODE_SLEEP;
                end
            end
            psdc_pkg::MODE_CLEAR: begin
                if (asyncDown) begin
                    next_st.mode = psdc_pkg::MODE_SLEEP;
                end else if (!counterClearBit) begin
                    next_st.mode = sleepBit ? psdc_pkg::MODE_SLEEP : psdc_pkg::MODE_RUN;
                end
            end
            psdc_pkg::MODE_SLEEP: begin
                if (chipEnable && !sleepBit) begin
                    next_st.mode = counterClearBit ? psdc_pkg::MODE_CLEAR
                                                   : psdc_pkg::MODE_RUN;
                end
            end
            default: begin
                next_st.mode = psdc_pkg::MODE_SLEEP;
            end
        endcase

        if (st.mode != psdc_pkg::MODE_RUN) begin
            // both dividers parked at their reload values, so they restart together
            next_st.refCnt  = refRatio;
            next_st.mainCnt = mainCount;
            next_st.swCnt   = swallowCount;
            next_st.refFlag = 1'b0;
            next_st.fbFlag  = 1'b0;
            next_st.refOut  = 1'b0;
            next_st.fbOut   = 1'b0;
        end else begin
            if (refEdge) begin
                // ratios below 2 are the host's fault; they give a pulse each edge
                if (st.refCnt <= 10'h001) begin
                    next_st.refCnt = refRatio;
                    refPulse       = 1'b1;
                end else begin
                    next_st.refCnt = st.refCnt - 10'h001;
                end
                next_st.refOut = refPulse;
            end
            if (preEdge) begin
                // total = 33*A + 32*(B-A) = 32*B + A prescaler input cycles
                if (st.mainCnt <= 10'h001) begin
                    next_st.mainCnt = mainCount;
                    next_st.swCnt   = swallowCount;
                    fbPulse         = 1'b1;
                end else begin
                    next_st.mainCnt = st.mainCnt - 10'h001;
                    if (st.swCnt != 5'h00) begin
                        next_st.swCnt = st.swCnt - 5'h01;
                    end
                end
                next_st.fbOut = fbPulse;
            end
            if (pumpFloatBit && !testBit) begin
                next_st.refFlag = 1'b0;
                next_st.fbFlag  = 1'b0;
            end else if ((st.refFlag | refPulse) && (st.fbFlag | fbPulse)) begin
                next_st.refFlag = 1'b0;
                next_st.fbFlag  = 1'b0;
            end else begin
                next_st.refFlag = st.refFlag | refPulse;
                next_st.fbFlag  = st.fbFlag | fbPulse;
            end
        end

        // reference ahead means feedback lags; polarity picks which way to pump
        upReq = detectorPolarityBit ? st.refFlag : st.fbFlag;
        dnReq = detectorPolarityBit ? st.fbFlag : st.refFlag;

        next_st.modulusSel    = (next_st.swCnt != 5'h00);
        next_st.refOscEnable  = (next_st.mode != psdc_pkg::MODE_SLEEP);
        next_st.rfInputEnable = (next_st.mode != psdc_pkg::MODE_SLEEP);
        // a pulse landing in the cycle that leaves run must not leave a flag set
        if (next_st.mode != psdc_pkg::MODE_RUN) begin
            next_st.refFlag = 1'b0;
            next_st.fbFlag  = 1'b0;
        end
        if (next_st.mode != psdc_pkg::MODE_RUN) begin
            next_st.pump = '{level: 1'b0, oeN: 1'b1};
        end else if (testBit) begin
            next_st.pump.level = detectorPolarityBit ? st.fbOut : st.refOut;
            next_st.pump.oeN   = 1'b0;
        end else if (pumpFloatBit) begin
            next_st.pump = '{level: 1'b0, oeN: 1'b1};
        end else if (upReq) begin
            next_st.pump = '{level: 1'b1, oeN: 1'b0};
        end else if (dnReq) begin
            next_st.pump = '{level: 1'b0, oeN: 1'b0};
        end else begin
            next_st.pump = '{level: 1'b0, oeN: 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st      <= '0;
            st.mode <= psdc_pkg::MODE_SLEEP;
            st.pump <= '{level: 1'b0, oeN: 1'b1};
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    assign modulusSel    = st.modulusSel;
    assign pumpOutput    = st.pump;
    assign refOscEnable  = st.refOscEnable;
    assign rfInputEnable = st.rfInputEnable;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence serialStep;
        clkEn && serEdge;
    endsequence
    sequence loadRef;
        clkEn && ldEdge && st.shiftReg[`PSDC_ADDR_BIT];
    endsequence
    sequence loadFb;
        clkEn && ldEdge && !st.shiftReg[`PSDC_ADDR_BIT];
    endsequence
    sequence testRun;
        clkEn && st.mode == psdc_pkg::MODE_RUN && testBit && chipEnable
            && !sleepBit && !counterClearBit;
    endsequence

    shift_in_a: assert property (serialStep |=> st.shiftReg[0] == $past(serialIn.data)
        && st.shiftReg[17:1] == $past(st.shiftReg[16:0]))
        else $error("serial bit not shifted in");
    ref_load_a: assert property (loadRef |=> st.refLatch == $past(st.shiftReg[14:1])
        && $stable(st.fbLatch))
        else $error("reference latch load wrong");
    fb_load_a: assert property (loadFb |=> st.fbLatch == $past(st.shiftReg[17:1])
        && $stable(st.refLatch))
        else $error("feedback latch load wrong");
    latch_hold_a: assert property (!ldEdge |=> $stable(st.refLatch)
        && $stable(st.fbLatch))
        else $error("latch changed without load");
    enable_down_a: assert property (clkEn && !chipEnable |=> pumpOutput.oeN
        && !refOscEnable && !rfInputEnable)
        else $error("enable pin low did not power down");
    sleep_float_a: assert property (st.mode == psdc_pkg::MODE_SLEEP |-> pumpOutput.oeN
        && !rfInputEnable && !st.refFlag && !st.fbFlag)
        else $error("asleep but pump or detector active");
    clear_park_a: assert property (st.mode == psdc_pkg::MODE_CLEAR && clkEn |=>
        st.refCnt == $past(refRatio) && st.mainCnt == $past(mainCount))
        else $error("counters not parked in clear");
    modulus_pick_a: assert property (modulusSel == (st.swCnt != 5'h00))
        else $error("modulus does not follow swallow count");
    ref_count_a: assert property (clkEn && st.mode == psdc_pkg::MODE_RUN && refEdge
        && st.refCnt > 10'h001 |=> st.refCnt == $past(st.refCnt) - 10'h001)
        else $error("reference counter did not step");
    detector_excl_a: assert property (!(st.refFlag && st.fbFlag))
        else $error("up and down held together");
    test_drive_a: assert property (testRun |=> !pumpOutput.oeN)
        else $error("test mode not driving pump pin");
    float_bit_a: assert property (clkEn && pumpFloatBit && !testBit |=>
        pumpOutput.oeN)
        else $error("float bit did not float pump");

endmodule

// *** bench/psdc_host_model.sv ***
// Purpose: host controller, reference oscillator and prescaler beside the synthesizer core
// Assumes: every level changes just after a rising clk edge
// Notes:   prescaler cycle is 4 clk, or 5 clk when the long modulus is asked for
`include "psdc_regs.svh"
module psdc_host_model (
    input  wire logic              clk,          // core clock
    input  wire logic              modulusSel,   // 1 asks for the long prescaler cycle
    output psdc_pkg::psdc_serial_t serialOut,    // serial clock, data, load strobe
    output logic                   refClockIn,   // reference oscillator level
    output logic                   prescalerOut  // prescaler output level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] refPhase = 3'h0;
    logic [2:0] prePhase = 3'h0;

    initial begin
        serialOut = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reference runs at 8 clk a period, well inside the 40 MHz limit
    always @(posedge clk) begin
        refPhase <= refPhase + 3'h1;
    end
    assign refClockIn = refPhase[2];

    // modulus is looked at late in the cycle so a one-clk update delay is harmless
    always @(posedge clk) begin
        if ((prePhase == 3'h3 && modulusSel !== 1'b1) || prePhase == 3'h4) begin
            prePhase <= 3'h0;
        end else begin
            prePhase <= prePhase + 3'h1;
        end
    end
    assign prescalerOut = (prePhase < 3'h2);

    ////////////////////////////////////////////////////////////////////////////////
    // serial clock stands low between frames; data is inverted once released
    task automatic send_word(input logic [`PSDC_SHIFT_W-1:0] word, input logic doLoad);
        for (int i = `PSDC_SHIFT_W - 1; i >= 0; i--) begin
            @(posedge clk) serialOut.data <= word[i];
            @(posedge clk) serialOut.clk <= 1'b1;
            repeat (2) @(posedge clk);
            serialOut.clk <= 1'b0;
        end
        if (doLoad) begin
            @(posedge clk) serialOut.load <= 1'b1;
            repeat (2) @(posedge clk);
            serialOut.load <= 1'b0;
        end
        @(posedge clk) serialOut.data <= ~word[0];
    endtask
endmodule

// *** bench/tb.sv ***
// Purpose: self-checking bench of the synthesizer core
// Assumes: test mode exposes divider outputs on the pump pin
// Notes:   periods are measured in clk cycles between pump pulse rises
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   clk;
    logic                   rst;
    logic                   clkEn;
    logic                   chipEnable;
    psdc_pkg::psdc_serial_t serialIn;
    psdc_pkg::psdc_pump_t   pumpOutput;
    logic                   refClockIn;
    logic                   prescalerOut;
    logic                   modulusSel;
    logic                   refOscEnable;
    logic                   rfInputEnable;
    int                     n_errors = 0;
    int                     n_tests = 0;
    int                     cycle = 0;
    int                     k;
    logic [9:0]             refTab [2] = '{10'h002, 10'h005};
    logic [14:0]            fbTab [5] = '{{10'h003, 5'h00}, {10'h003, 5'h03}, {10'h01f, 5'h00},
                                          {10'h3ff, 5'h1f}, {10'h005, 5'h02}};
    logic [1:0]             ctlTab [3] = '{2'h3, 2'h0, 2'h1};
    logic [2:0]             pwrTab [3] = '{3'h4, 3'h3, 3'h4};

    initial clk = 1'b0;
    always #2.5 clk = ~clk;
    always @(posedge clk) cycle <= cycle + 1;

    psdc_core uut (.clk(clk), .rst(rst), .clkEn(clkEn), .serialIn(serialIn),
        .chipEnable(chipEnable), .refClockIn(refClockIn), .prescalerOut(prescalerOut),
        .modulusSel(modulusSel), .pumpOutput(pumpOutput), .refOscEnable(refOscEnable),
        .rfInputEnable(rfInputEnable));
    psdc_host_model host (.clk(clk), .modulusSel(modulusSel), .serialOut(serialIn),
        .refClockIn(refClockIn), .prescalerOut(prescalerOut));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [17:0] refWord(input logic [9:0] ratio, input logic flt,
                                            input logic pol, input logic tst);
        return {3'h0, tst, 1'b0, pol, flt, ratio, 1'b1};
    endfunction
    function automatic logic [17:0] fbWord(input logic [9:0] b, input logic [4:0] a,
                                           input logic [1:0] ctl);
        return {b, a, ctl, 1'b0};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic next_pulse(output int stamp);
        int n;
        for (n = 0; n < 20000 && pumpOutput.level !== 1'b0; n++) @(posedge clk);
        for (; n < 20000 && pumpOutput.level !== 1'b1; n++) @(posedge clk);
        stamp = cycle;
    endtask
    // first pulse is skipped: it may belong to the ratio before the reload
    task automatic measure(input int exp);
        int a;
        int b;
        next_pulse(a);
        next_pulse(a);
        next_pulse(b);
        check(b - a, exp);
    endtask
    task automatic report_and_stop();
        $display("errors=%0d tests=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        clkEn = 1'b1;
        chipEnable = 1'b1;
        repeat (2) @(posedge clk);
        check({modulusSel, pumpOutput.oeN, refOscEnable, rfInputEnable}, 4'h4);
        rst <= 1'b0;
        host.send_word(fbWord(10'h003, 5'h00, 2'h0), 1'b1);
        foreach (refTab[i]) begin
            host.send_word(refWord(refTab[i], 1'b1, 1'b0, 1'b1), 1'b1);
            measure(8 * refTab[i]);
        end
        host.send_word(refWord(10'h002, 1'b1, 1'b1, 1'b1), 1'b1);
        foreach (fbTab[i]) begin
            host.send_word(fbWord(fbTab[i][14:5], fbTab[i][4:0], 2'h0), 1'b1);
            measure(4 * fbTab[i][14:5] + fbTab[i][4:0]);
        end
        host.send_word(refWord(10'h002, 1'b1, 1'b0, 1'b1), 1'b0);
        measure(22);
        for (int p = 1; p >= 0; p--) begin
            host.send_word(refWord(10'h002, 1'b0, p[0], 1'b0), 1'b1);
            host.send_word(fbWord(10'h00a, 5'h00, 2'h2), 1'b1);
            repeat (4) @(posedge clk);
            check(pumpOutput.oeN, 1'b1);
            host.send_word(fbWord(10'h00a, 5'h00, 2'h0), 1'b1);
            for (k = 0; k < 200 && pumpOutput.oeN !== 1'b0; k++) @(posedge clk);
            check(pumpOutput.level, p[0]);
        end
        host.send_word(refWord(10'h002, 1'b1, 1'b1, 1'b0), 1'b1);
        repeat (4) @(posedge clk);
        k = 0;
        repeat (100) begin
            @(posedge clk);
            if (pumpOutput.oeN !== 1'b1) k++;
        end
        check(k, 0);
        chipEnable <= 1'b0;
        host.send_word(refWord(10'h005, 1'b1, 1'b0, 1'b1), 1'b1);
        check({pumpOutput.oeN, refOscEnable, rfInputEnable}, 3'h4);
        chipEnable <= 1'b1;
        measure(40);
        foreach (ctlTab[i]) begin
            host.send_word(fbWord(10'h003, 5'h00, ctlTab[i]), 1'b1);
            repeat (40) @(posedge clk);
            check({pumpOutput.oeN, refOscEnable, rfInputEnable}, pwrTab[i]);
        end
        report_and_stop();
    end
endmodule
